// file: core/lsu_pkg.sv
package lsu_pkg;

	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int LANES = 16; // Bytes per cache data port
	localparam int OFF_W = 4; // Byte offset within the port
	localparam int IDX_W = 60; // Port word index
	localparam int GR_NUM = 128; // General registers tracked
	localparam int GR_W = 7;
	localparam int SRC_BYTES = 10; // Widest store source (FP memory format)
	localparam int REG_BYTES = 8; // Integer register bytes

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_NS = 10;
	localparam int LOAD_LAT_NS = 20; // Load to use latency
	localparam int LOAD_LAT_CYC = (LOAD_LAT_NS + CLK_NS - 1) / CLK_NS;

	// ----------------------------------------
	// Operations and sizes
	// ----------------------------------------
	typedef enum logic [1:0] {OP_LOAD, OP_STORE, OP_FSTORE, OP_PREFETCH} lsu_op_t;
	typedef enum logic [2:0] {SZ_1, SZ_2, SZ_4, SZ_8, SZ_10} lsu_size_t;

	// Issue request from the pipeline
	typedef struct packed {
		logic valid;
		lsu_op_t op;
		lsu_size_t size;
		logic [63:0] addr;
		logic [8*SRC_BYTES-1:0] data;
		logic [GR_W-1:0] dst;
	} lsu_req_t;

	// Cache data port
	typedef struct packed {
		logic rd;
		logic wr;
		logic [IDX_W-1:0] idx;
		logic [LANES-1:0] be;
		logic [8*LANES-1:0] wdata;
	} lsu_mem_t;

	// Register write-back
	typedef struct packed {
		logic valid;
		logic [GR_W-1:0] dst;
		logic [63:0] data;
	} lsu_wb_t;

	// Byte count of an access size
	function automatic logic [4:0] lsu_nbytes(input lsu_size_t s);
		unique case (s)
			SZ_1: lsu_nbytes = 5'h01;
			SZ_2: lsu_nbytes = 5'h02;
			SZ_4: lsu_nbytes = 5'h04;
			SZ_8: lsu_nbytes = 5'h08;
			SZ_10: lsu_nbytes = 5'h0a;
			default: lsu_nbytes = 5'h00;
		endcase
	endfunction

endpackage

// file: core/lsu_order.sv
`timescale 1ns/1ns
`default_nettype none
// Byte order unit: reverses the first n bytes when big-endian is selected
module lsu_order
	import lsu_pkg::*;
(
	input wire logic [8*SRC_BYTES-1:0] i_data,
	input wire logic [4:0] i_nbytes,
	input wire logic i_big,
	output logic [8*SRC_BYTES-1:0] o_data
);

	// ----------------------------------------
	// Reversal
	// ----------------------------------------
	// Same unit serves loads and stores, so a round trip is the identity
	always_comb begin
		o_data = i_data;
		for (int i = 0; i < SRC_BYTES; i++) begin
			if (i_big && (5'(i) < i_nbytes)) begin
				o_data[8*i +: 8] = i_data[8*(32'(i_nbytes) - 1 - i) +: 8];
			end
		end
	end

endmodule
`default_nettype wire

// file: core/lsu_scbd.sv
`timescale 1ns/1ns
`default_nettype none
// Pending-load scoreboard, one flag per general register
module lsu_scbd
	import lsu_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_set,
	input wire logic [GR_W-1:0] i_set_idx,
	input wire logic i_clr,
	input wire logic [GR_W-1:0] i_clr_idx,
	output logic [GR_NUM-1:0] o_pend_q
);

	// ----------------------------------------
	// Flags
	// ----------------------------------------
	// A new load to the register that is just retiring keeps it pending
	for (genvar g = 0; g < GR_NUM; g++) begin : g_flag
		always_ff @(posedge i_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				o_pend_q[g] <= 1'b0;
			end else if (i_set && i_set_idx == GR_W'(g)) begin
				o_pend_q[g] <= 1'b1;
			end else if (i_clr && i_clr_idx == GR_W'(g)) begin
				o_pend_q[g] <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// file: core/lsu_top.sv
// Notes on behaviour
// - Integer stores write 1, 2, 4, 8 bytes
// - FP stores write 4, 8, 10 bytes
// - Narrow stores take lowest register bytes
// - Little-endian default, byte order bit selects big
// - Integer loads read 1, 2, 4, 8 bytes
// - Narrow loads zero-extend to 64 bits
// - Line prefetch hints are dropped harmlessly
// - Memory dependencies in group follow program order
// - Same-address stores leave the later value
// - Store then overlapping load sees store data
// - Load data usable two cycles after issue
`timescale 1ns/1ns
`default_nettype none
module lsu_top
	import lsu_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire lsu_req_t i_req,
	input wire logic i_byte_order_select_bit,
	input wire logic [8*LANES-1:0] i_mem_rdata,
	output lsu_mem_t o_mem_q,
	output lsu_wb_t o_wb_q,
	output logic [GR_NUM-1:0] o_pend_q,
	output logic o_bad_q
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic [1:0] rst_sync_q; // Release shifter
	logic rst_n; // Synchronised reset

	// Async assert, release after two edges
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ----------------------------------------
	// Request decode
	// ----------------------------------------
	logic [4:0] nbytes; // Access width in bytes
	logic [OFF_W-1:0] off; // Byte lane of first byte
	logic size_ok; // Width legal for the operation
	logic fits; // Access stays inside one port word
	logic is_ld; // Legal load accepted
	logic is_st; // Legal store accepted

	// Width legality per operation kind
	always_comb begin
		nbytes = lsu_nbytes(i_req.size);
		off = i_req.addr[OFF_W-1:0];
		fits = (5'(off) + nbytes) <= 5'(LANES);
		unique case (i_req.op)
			// Integer widths only
			OP_LOAD, OP_STORE: size_ok = i_req.size inside {SZ_1, SZ_2, SZ_4, SZ_8};
			// FP widths only
			OP_FSTORE: size_ok = i_req.size inside {SZ_4, SZ_8, SZ_10};
			// Hint carries no width
			OP_PREFETCH: size_ok = 1'b0;
		endcase
		is_ld = i_req.valid && i_req.op == OP_LOAD && size_ok && fits;
		is_st = i_req.valid && (i_req.op == OP_STORE || i_req.op == OP_FSTORE) && size_ok && fits;
	end

	// ----------------------------------------
	// Store data path
	// ----------------------------------------
	logic [8*SRC_BYTES-1:0] st_ord; // Source bytes in memory order
	logic [8*LANES-1:0] st_lanes; // Source widened to the port
	logic [LANES-1:0] st_mask; // Bytes written before shifting

	// Low source bytes, reordered if big-endian
	lsu_order u_st_order (
		.i_data(i_req.data),
		.i_nbytes(nbytes),
		.i_big(i_byte_order_select_bit),
		.o_data(st_ord)
	);

	// Mask of exactly the written bytes
	always_comb begin
		st_lanes = {{(8*(LANES-SRC_BYTES)){1'b0}}, st_ord};
		st_mask = LANES'((17'h00001 << nbytes) - 17'h00001);
	end

	// ----------------------------------------
	// Cache port
	// ----------------------------------------
	// One access per cycle in issue order: an earlier store always
	// reaches the cache before a later load or store touches it
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			o_mem_q <= '0;
		end else begin
			o_mem_q.rd <= is_ld;
			o_mem_q.wr <= is_st;
			o_mem_q.idx <= i_req.addr[63:OFF_W];
			// Loads drive no byte enables
			o_mem_q.be <= is_st ? (st_mask << off) : '0;
			o_mem_q.wdata <= st_lanes << {off, 3'h0};
		end
	end

	// ----------------------------------------
	// Load tracking
	// ----------------------------------------
	logic ld_v_q; // Load reading the cache this cycle
	logic [GR_W-1:0] ld_dst_q; // Its destination
	logic [OFF_W-1:0] ld_off_q; // Its byte lane
	logic [4:0] ld_nb_q; // Its width
	logic ld_big_q; // Byte order at issue

	// Capture load attributes alongside the cache read
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			ld_v_q <= 1'b0;
			ld_dst_q <= '0;
			ld_off_q <= '0;
			ld_nb_q <= '0;
			ld_big_q <= 1'b0;
		end else begin
			ld_v_q <= is_ld;
			ld_dst_q <= i_req.dst;
			ld_off_q <= off;
			ld_nb_q <= nbytes;
			ld_big_q <= i_byte_order_select_bit;
		end
	end

	// ----------------------------------------
	// Load data path
	// ----------------------------------------
	logic [8*LANES-1:0] ld_shift; // Read word moved to lane zero
	logic [8*SRC_BYTES-1:0] ld_ord; // Bytes in register order
	logic [63:0] ld_mask; // Keeps only the loaded bytes

	// Align to lane zero
	always_comb begin
		ld_shift = i_mem_rdata >> {ld_off_q, 3'h0};
		ld_mask = 64'((65'h1 << {ld_nb_q, 3'h0}) - 65'h1);
	end

	// Same reversal as stores, so round trips are exact
	lsu_order u_ld_order (
		.i_data(ld_shift[8*SRC_BYTES-1:0]),
		.i_nbytes(ld_nb_q),
		.i_big(ld_big_q),
		.o_data(ld_ord)
	);

	// ----------------------------------------
	// Write-back
	// ----------------------------------------
	// Result registered at the end of the read cycle: usable two
	// cycles after issue, with no extra cache stage in between
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			o_wb_q <= '0;
		end else begin
			o_wb_q.valid <= ld_v_q;
			o_wb_q.dst <= ld_dst_q;
			o_wb_q.data <= ld_ord[63:0] & ld_mask;
		end
	end

	// ----------------------------------------
	// Use interlock
	// ----------------------------------------
	// Issue stalls a reader while its flag is set; register hazards
	// inside a group are the producer's problem and are not checked
	lsu_scbd u_scbd (
		.i_clk(i_mclk),
		.i_rst_n(rst_n),
		.i_set(is_ld),
		.i_set_idx(i_req.dst),
		.i_clr(ld_v_q),
		.i_clr_idx(ld_dst_q),
		.o_pend_q(o_pend_q)
	);

	// ----------------------------------------
	// Dropped requests
	// ----------------------------------------
	// Hints vanish silently; bad widths or line-crossing accesses flag
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			o_bad_q <= 1'b0;
		end else begin
			o_bad_q <= i_req.valid && i_req.op != OP_PREFETCH && !is_ld && !is_st;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_st_width;
		@(posedge i_mclk) disable iff (!rst_n)
		is_st |=> o_mem_q.wr && ($countones(o_mem_q.be) == 32'($past(nbytes)));
	endproperty
	a_st_width: assert property (p_st_width) else $error("store byte count wrong");

	property p_fp10;
		@(posedge i_mclk) disable iff (!rst_n)
		is_st && i_req.op == OP_FSTORE && i_req.size == SZ_10 |=> $countones(o_mem_q.be) == 10;
	endproperty
	a_fp10: assert property (p_fp10) else $error("ten byte store wrong");

	property p_little;
		@(posedge i_mclk) disable iff (!rst_n)
		is_st && !i_byte_order_select_bit && i_req.size == SZ_4 && off == '0
			|=> o_mem_q.wdata[31:0] == $past(i_req.data[31:0]);
	endproperty
	a_little: assert property (p_little) else $error("little store data wrong");

	property p_big;
		@(posedge i_mclk) disable iff (!rst_n)
		is_st && i_byte_order_select_bit && i_req.size == SZ_4 && off == '0
			|=> o_mem_q.wdata[7:0] == $past(i_req.data[31:24]);
	endproperty
	a_big: assert property (p_big) else $error("big store data wrong");

	property p_ld_lat;
		@(posedge i_mclk) disable iff (!rst_n)
		is_ld |=> o_mem_q.rd ##1 (o_wb_q.valid && o_wb_q.dst == $past(i_req.dst, 2));
	endproperty
	a_ld_lat: assert property (p_ld_lat) else $error("load latency wrong");

	property p_pend;
		@(posedge i_mclk) disable iff (!rst_n)
		is_ld |=> o_pend_q[$past(i_req.dst)];
	endproperty
	a_pend: assert property (p_pend) else $error("load not marked pending");

	property p_zext;
		@(posedge i_mclk) disable iff (!rst_n)
		ld_v_q && ld_nb_q == 5'h01 |=> o_wb_q.data[63:8] == '0;
	endproperty
	a_zext: assert property (p_zext) else $error("load not zero extended");

	property p_ld_big;
		@(posedge i_mclk) disable iff (!rst_n)
		ld_v_q && ld_big_q && ld_nb_q == 5'h08 && ld_off_q == '0
			|=> o_wb_q.data[7:0] == $past(i_mem_rdata[63:56]);
	endproperty
	a_ld_big: assert property (p_ld_big) else $error("big load order wrong");

	property p_hint;
		@(posedge i_mclk) disable iff (!rst_n)
		i_req.valid && i_req.op == OP_PREFETCH |=> !o_mem_q.rd && !o_mem_q.wr && !o_bad_q;
	endproperty
	a_hint: assert property (p_hint) else $error("hint reached the cache");

	property p_st_addr;
		@(posedge i_mclk) disable iff (!rst_n)
		is_st |=> o_mem_q.idx == $past(i_req.addr[63:OFF_W]);
	endproperty
	a_st_addr: assert property (p_st_addr) else $error("store address wrong");

	// Illegal widths must never reach the cache
	property p_bad_drop;
		@(posedge i_mclk) disable iff (!rst_n)
		i_req.valid && i_req.op != OP_PREFETCH && !size_ok
			|=> o_bad_q && !o_mem_q.rd && !o_mem_q.wr;
	endproperty
	a_bad_drop: assert property (p_bad_drop) else $error("bad width not dropped");

	property p_ld_no_be;
		@(posedge i_mclk) disable iff (!rst_n)
		is_ld |=> o_mem_q.rd && !o_mem_q.wr && o_mem_q.be == '0;
	endproperty
	a_ld_no_be: assert property (p_ld_no_be) else $error("load drove byte enables");

	// A retiring load frees its register unless a new load claims it
	property p_pend_clr;
		@(posedge i_mclk) disable iff (!rst_n)
		ld_v_q && !(is_ld && i_req.dst == ld_dst_q) |=> !o_pend_q[$past(ld_dst_q)];
	endproperty
	a_pend_clr: assert property (p_pend_clr) else $error("pending flag not cleared");

	property p_zext4;
		@(posedge i_mclk) disable iff (!rst_n)
		ld_v_q && ld_nb_q == 5'h04 |=> o_wb_q.data[63:32] == '0;
	endproperty
	a_zext4: assert property (p_zext4) else $error("word load not zero extended");

	// Store issued first reaches the cache one cycle ahead of the load
	property p_st_then_ld;
		@(posedge i_mclk) disable iff (!rst_n)
		is_st ##1 is_ld |=> o_mem_q.rd && $past(o_mem_q.wr);
	endproperty
	a_st_then_ld: assert property (p_st_then_ld) else $error("store after load");

	c_load: cover property (@(posedge i_mclk) disable iff (!rst_n) is_ld ##2 o_wb_q.valid);
	c_big_st: cover property (@(posedge i_mclk) disable iff (!rst_n)
		is_st && i_byte_order_select_bit);
	c_st_ld: cover property (@(posedge i_mclk) disable iff (!rst_n) is_st ##1 is_ld);
	c_big_ld: cover property (@(posedge i_mclk) disable iff (!rst_n) ld_v_q && ld_big_q);
	c_fp10: cover property (@(posedge i_mclk) disable iff (!rst_n)
		is_st && i_req.size == SZ_10);

endmodule
`default_nettype wire

// file: sim/lsu_cache_model.sv
`timescale 1ns/1ns
`default_nettype none
// Cache data port model: 16 port words folded on the low index bits
module lsu_cache_model
	import lsu_pkg::*;
(
	input wire logic i_clk,
	input wire lsu_mem_t i_mem,
	output logic [8*LANES-1:0] o_rdata
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [8*LANES-1:0] mem_q [16]; // Folded backing words
	logic [8*LANES-1:0] last_q; // Last answer given

	// Writes land at the edge closing the write cycle, so a later read sees them
	always_ff @(posedge i_clk) begin
		for (int b = 0; b < LANES; b++) begin
			if (i_mem.wr && i_mem.be[b]) begin
				mem_q[i_mem.idx[3:0]][8*b+:8] <= i_mem.wdata[8*b+:8];
			end
		end
		if (i_mem.rd) begin
			last_q <= o_rdata;
		end
	end

	// Same-cycle answer; outside a read the port shows junk, not stale data
	always_comb begin
		o_rdata = i_mem.rd ? mem_q[i_mem.idx[3:0]] : ~last_q;
	end
endmodule
`default_nettype wire

// file: sim/lsu_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module lsu_top_test;
	import lsu_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam logic [6:0] DST = 7'h2a; // Load target register
	logic clk = 1'b0;
	logic nrst = 1'b0;
	lsu_req_t req = '0;
	logic big = 1'b0; // Byte order select
	logic [8*LANES-1:0] rdata;
	lsu_mem_t mem;
	lsu_wb_t wb;
	logic [GR_NUM-1:0] pend;
	logic bad;
	int err_total = 0;
	int samples_checked = 0;
	lsu_size_t szs [4] = '{SZ_1, SZ_2, SZ_4, SZ_8};
	lsu_size_t fsz [3] = '{SZ_4, SZ_8, SZ_10};
	int ns [4] = '{1, 2, 4, 8};
	int fns [3] = '{4, 8, 10};
	logic [79:0] dat = 80'haa99_8877_6655_4433_2211;

	always #5 clk = ~clk;

	lsu_top lsu_top_i (.i_mclk(clk), .i_nrst(nrst), .i_req(req),
		.i_byte_order_select_bit(big), .i_mem_rdata(rdata), .o_mem_q(mem),
		.o_wb_q(wb), .o_pend_q(pend), .o_bad_q(bad));
	lsu_cache_model lsu_cache_model_i (.i_clk(clk), .i_mem(mem), .o_rdata(rdata));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic summarize;
		$display("checks=%0d errors=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Expected lane image of n source bytes at offset off
	function automatic logic [127:0] place(input logic [79:0] d, input int n, input int off,
		input logic b);
		logic [127:0] r;
		r = '0;
		for (int k = 0; k < n; k++) begin
			r[8*(off+k)+:8] = b ? d[8*(n-1-k)+:8] : d[8*k+:8];
		end
		return r;
	endfunction

	// One request for one cycle; back-to-back calls keep valid high
	task automatic drv(input lsu_op_t op, input lsu_size_t sz, input logic [63:0] a,
		input logic [79:0] d, input logic b);
		@(negedge clk);
		req.valid = 1'b1;
		req.op = op;
		req.size = sz;
		req.addr = a;
		req.data = d;
		req.dst = DST;
		big = b;
	endtask

	task automatic idle;
		@(negedge clk);
		req.valid = 1'b0;
	endtask

	// Store, then judge enables and lane data in the write cycle
	task automatic st(input lsu_op_t op, input lsu_size_t sz, input logic [63:0] a,
		input int n, input logic b);
		logic [15:0] be;
		be = '0;
		for (int k = 0; k < n; k++) be[a[3:0]+k] = 1'b1;
		drv(op, sz, a, dat, b);
		idle();
		chk({mem.wr, mem.rd, mem.idx}, {2'b10, a[63:4]});
		chk(mem.be, be);
		chk(mem.wdata & place('1, n, a[3:0], 1'b0), place(dat, n, a[3:0], b));
	endtask

	// Load, then judge pending flag, read strobe and the result two cycles on
	task automatic ld(input lsu_size_t sz, input logic [63:0] a, input logic b,
		input logic [63:0] exp);
		drv(OP_LOAD, sz, a, '0, b);
		idle();
		chk({mem.rd, mem.wr, pend[DST]}, 3'b101);
		// Destination is read only once the result stands
		@(negedge clk);
		chk({wb.valid, wb.dst, pend[DST]}, {1'b1, DST, 1'b0});
		chk(wb.data, exp);
	endtask

	// Dropped requests: only the drop flag may answer
	task automatic drop(input lsu_op_t op, input lsu_size_t sz, input logic [63:0] a,
		input logic f);
		drv(op, sz, a, dat, 1'b0);
		idle();
		chk({bad, mem.wr, mem.rd}, {f, 2'b00});
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_int;
		logic [63:0] a;
		for (int b = 0; b < 2; b++) begin
			for (int i = 0; i < 4; i++) begin
				a = 64'h1000 + 64'(16 * i) + 64'(16 - ns[i]);
				st(OP_STORE, szs[i], a, ns[i], b[0]);
				ld(szs[i], a, b[0], dat[63:0] & ((64'h1 << (8 * ns[i])) - 64'h1));
			end
		end
	endtask

	task automatic t_fp;
		for (int i = 0; i < 3; i++) st(OP_FSTORE, fsz[i], 64'h2006 - 64'(fns[i] - 4), fns[i], 1'b0);
		drop(OP_STORE, SZ_10, 64'h2000, 1'b1);
		drop(OP_FSTORE, SZ_1, 64'h2000, 1'b1);
		drop(OP_LOAD, SZ_10, 64'h2000, 1'b1);
		drop(OP_STORE, SZ_8, 64'h200c, 1'b1);
		drop(OP_PREFETCH, SZ_8, 64'h2000, 1'b0);
	endtask

	// Two stores to one place and an overlapping load, all back to back
	task automatic t_order;
		drv(OP_STORE, SZ_8, 64'h3008, 80'h1111_2222_3333_4444, 1'b0);
		drv(OP_STORE, SZ_8, 64'h3008, 80'h5555_6666_7777_8888, 1'b0);
		drv(OP_LOAD, SZ_4, 64'h300c, '0, 1'b0);
		idle();
		chk(mem.rd, 1'b1);
		@(negedge clk);
		chk(wb.data, 64'h5555_6666);
		ld(SZ_8, 64'h3008, 1'b0, 64'h5555_6666_7777_8888);
	endtask

	initial begin
		repeat (16) @(posedge clk);
		chk({mem.rd, mem.wr, wb.valid, bad}, 4'h0);
		@(negedge clk);
		nrst = 1'b1;
		repeat (3) @(posedge clk);
		t_int();
		t_fp();
		t_order();
		summarize();
	end

	// Hang guard
	initial begin
		repeat (3000) @(posedge clk);
		err_total++;
		summarize();
	end
endmodule
`default_nettype wire
